// ---- rtl/pci_bridge_pkg.sv ----
// shared constants and types for the processor-to-pci bridge link
package pci_bridge_pkg;
  localparam logic [2:0] MABORT_CLKS = 3'h5;
  localparam int CTL_FRAME = 4;
  localparam int CTL_IRDY = 3;
  localparam int CTL_TRDY = 2;
  localparam int CTL_DEVSEL = 1;
  localparam int CTL_STOP = 0;
  localparam logic [4:0] CTL_IDLE = 5'h1F;
  localparam logic [3:0] DEV_WIN = 4'h0;
  localparam logic [3:0] AGT_WIN = 4'h8;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] AD_RESET = 32'h00000000;
  localparam logic [1:0] SYNC_RESET = 2'h1;
  typedef enum logic [1:0] {
    TERM_OK = 2'h0, TERM_RETRY = 2'h1, TERM_TABORT = 2'h2,
    TERM_MABORT = 2'h3
  } term_t;
  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_ADDR = 4'h2, M_DATA = 4'h4, M_TURN = 4'h8
  } mst_t;
  typedef enum logic [4:0] {
    A_IDLE = 5'h01, A_REQ = 5'h02, A_ADDR = 5'h04, A_DATA = 5'h08,
    A_TURN = 5'h10
  } agt_t;
  typedef enum logic [4:0] {
    T_IDLE = 5'h01, T_CLAIM = 5'h02, T_DATA = 5'h04, T_STOP = 5'h08,
    T_TURN = 5'h10
  } tgt_t;
endpackage

// ---- rtl/pci_link_if.sv ----
// pci/vl link between the bridge and the peripheral-side agent
`timescale 1ns/1ps
`default_nettype none
interface pci_link_if (input wire logic local_bus_clock);
  logic [31:0] ad, devAd, agtAd;
  logic devAdOe, agtAdOe;
  logic [3:0] cbe, devCbe, agtCbe;
  logic devCbeOe, agtCbeOe;
  logic [4:0] ctl, devCtl, devCtlOe, agtCtl, agtCtlOe;
  logic peripheral_bus_request;
  logic isaMaster;
  logic gnt;
  logic pci_atomic_flag_n;
  localparam logic [31:0] ALL_ONES_W = 32'hFFFFFFFF;
  // undriven lines float high through the pull-ups
  assign ad = devAdOe ? devAd : (agtAdOe ? agtAd : ALL_ONES_W);
  assign cbe = devCbeOe ? devCbe : (agtCbeOe ? agtCbe : 4'hF);
  assign ctl = (devCtlOe & devCtl) | (~devCtlOe & agtCtlOe & agtCtl)
             | (~devCtlOe & ~agtCtlOe);
  modport dev (input local_bus_clock, ad, cbe, ctl, peripheral_bus_request,
    isaMaster, output devAd, devAdOe, devCbe, devCbeOe, devCtl, devCtlOe,
    gnt, pci_atomic_flag_n);
  modport agt (input local_bus_clock, ad, cbe, ctl, gnt, pci_atomic_flag_n,
    output agtAd, agtAdOe, agtCbe, agtCbeOe, agtCtl, agtCtlOe,
    peripheral_bus_request, isaMaster);
endinterface
`default_nettype wire

// ---- rtl/pci_bridge_device.sv ----
// bridge end: processor cycles to pci master, pci target, hold arbitration
// Operation
// [R1] non-local processor cycles become pci cycles
// [R2] command/byte enables driven as master, sampled otherwise
// [R3] owner frames access; frame input when target
// [R4] data moves only when both readies asserted
// [R5] drive initiator-ready as master, sample as target
// [R6] drive target-ready only as addressed target
// [R7] claim with device-select; sample it as master
// [R8] no device-select in time: master abort
// [R9] stop seen: frame released within three clocks
// [R10] tell disconnect, retry, abort apart; generate some
// [R11] target stop held until frame released
// [R12] address/data driven during reset
// [R13] isa low address taken from address/data
// [R14] request pin sampled at reset as test strap
// [R15] processor floats bus then acknowledges grant
// [R16] hand bus over only after grant acknowledge
// [R17] address float while snoop address driven
// [R18] atomic flag follows processor lock
// [R19] back-off on potential bridge deadlock
// [R20] atomic flag does not block unlocked accesses
// [R21] five clocks for device-select, then all-ones read
`timescale 1ns/1ps
`default_nettype none
module pci_bridge_device
  import pci_bridge_pkg::*;
(
  input wire logic local_bus_clock,
  input wire logic rstn,
  pci_link_if.dev link,
  input wire logic cpuReq,
  input wire logic cpuLocal,
  input wire logic [3:0] cpuCmd,
  input wire logic [31:0] cpuAddr,
  input wire logic [3:0] cpuByteEn,
  input wire logic [31:0] cpuWrData,
  input wire logic cpuLockN,
  input wire logic snoopReq,
  input wire logic tgtRetry,
  input wire logic cpu_grant_ack,
  output logic cpuDone,
  output logic [31:0] cpuRdData,
  output logic [1:0] cpuTerm,
  output logic cpuHold,
  output logic cpu_address_float,
  output logic cpu_backoff_n,
  output logic testMode,
  output logic [8:0] isa_low_address
);
  logic [1:0] syncA_r, syncB_r;
  logic ackS, lockNS;
  logic frameN, irdyN, trdyN, devselN, stopN;
  logic pend_r, mWr;
  logic [31:0] mAddr_r, mData_r;
  logic [3:0] mCmd_r, mBe_r;
  mst_t mState_r, mNxt;
  tgt_t tState_r, tNxt;
  logic [2:0] cnt_r;
  logic mEnd, start, prevFrameN_r;
  term_t term;
  logic [1:0] tIdx_r;
  logic tWr_r, tRetry_r, hold_r, gnt_r;
  logic [31:0] tMem [4];

  assign frameN = link.ctl[CTL_FRAME];
  assign irdyN = link.ctl[CTL_IRDY];
  assign trdyN = link.ctl[CTL_TRDY];
  assign devselN = link.ctl[CTL_DEVSEL];
  assign stopN = link.ctl[CTL_STOP];
  assign ackS = syncB_r[1];
  assign lockNS = syncB_r[0];
  assign mWr = mCmd_r[0];
  assign link.gnt = gnt_r;
  assign cpuHold = hold_r;

  // grant acknowledge and lock are processor pins: two flops first
  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      syncA_r <= SYNC_RESET;
      syncB_r <= SYNC_RESET;
    end else begin
      syncA_r <= {cpu_grant_ack, cpuLockN};
      syncB_r <= syncA_r;
    end
  end

  // local-memory cycles are served elsewhere and never reach the bus
  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      pend_r <= 1'b0;
    end else if (cpuReq && !cpuLocal) begin
      // a request in the turn cycle must not be lost
      pend_r <= 1'b1; // see [R1]
    end else if (mState_r == M_TURN) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge local_bus_clock) begin
    if (cpuReq && (!pend_r || mState_r == M_TURN)) begin
      mAddr_r <= cpuAddr;
      mCmd_r <= cpuCmd;
      mBe_r <= cpuByteEn;
      mData_r <= cpuWrData;
    end
  end

  assign start = pend_r && !hold_r && !gnt_r && tState_r == T_IDLE
    && frameN && irdyN;
  // single data phase: frame is already high in the data phase, so a
  // stop is honoured with zero added clocks
  assign mEnd = mState_r == M_DATA && ((!trdyN && !devselN) || !stopN
    || (devselN && cnt_r >= MABORT_CLKS)); // see [R4] [R8] [R9] [R21]

  always_comb begin
    if (!trdyN && !devselN) begin
      term = TERM_OK;
    end else if (!stopN && !devselN) begin
      term = TERM_RETRY; // see [R10]
    end else if (!stopN) begin
      term = TERM_TABORT; // see [R7] [R10]
    end else begin
      term = TERM_MABORT;
    end
  end

  always_comb begin
    mNxt = mState_r;
    unique case (mState_r)
      M_IDLE: if (start) mNxt = M_ADDR;
      M_ADDR: mNxt = M_DATA;
      M_DATA: if (mEnd) mNxt = M_TURN;
      M_TURN: mNxt = M_IDLE;
    endcase
  end

  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      mState_r <= M_IDLE;
      cnt_r <= 3'h0;
    end else begin
      mState_r <= mNxt;
      cnt_r <= (mState_r == M_IDLE) ? 3'h0 : cnt_r + 3'h1;
    end
  end

  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      cpuDone <= 1'b0;
      cpuRdData <= ALL_ONES;
      cpuTerm <= TERM_OK;
    end else begin
      cpuDone <= mEnd;
      if (mEnd) begin
        cpuTerm <= term;
        cpuRdData <= (term == TERM_OK) ? link.ad : ALL_ONES; // see [R21]
      end
    end
  end

  // target side: claim on an address phase in our window
  always_comb begin
    tNxt = tState_r;
    unique case (tState_r)
      T_IDLE: begin
        if (!frameN && prevFrameN_r && mState_r == M_IDLE
            && link.ad[31:28] == DEV_WIN) begin
          tNxt = T_CLAIM; // see [R3] [R20]
        end
      end
      T_CLAIM: tNxt = tRetry_r ? T_STOP : T_DATA;
      T_DATA: if (!irdyN) tNxt = frameN ? T_TURN : T_STOP; // see [R5]
      T_STOP: if (frameN) tNxt = T_TURN; // see [R11]
      T_TURN: tNxt = T_IDLE;
    endcase
  end

  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      tState_r <= T_IDLE;
      prevFrameN_r <= 1'b1;
    end else begin
      tState_r <= tNxt;
      prevFrameN_r <= frameN;
    end
  end

  always_ff @(posedge local_bus_clock) begin
    if (tState_r == T_IDLE) begin
      tIdx_r <= link.ad[3:2];
      tWr_r <= link.cbe[0]; // see [R2]
      tRetry_r <= tgtRetry;
    end
    if (tState_r == T_DATA && !irdyN && tWr_r) begin
      tMem[tIdx_r] <= link.ad; // see [R4]
    end
  end

  // bus pins: every value comes from a flop, decided by the next states
  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      link.devAd <= AD_RESET;
      link.devAdOe <= 1'b1; // see [R12]
      link.devCbe <= 4'hF;
      link.devCbeOe <= 1'b0;
      link.devCtl <= CTL_IDLE;
      link.devCtlOe <= 5'h00;
    end else begin
      link.devAd <= mData_r;
      link.devAdOe <= 1'b0;
      link.devCbe <= mBe_r;
      link.devCbeOe <= mNxt inside {M_ADDR, M_DATA}; // see [R2]
      if (mNxt == M_ADDR) begin
        link.devAd <= mAddr_r;
        link.devAdOe <= 1'b1; // see [R1]
        link.devCbe <= mCmd_r;
      end else if (mNxt == M_DATA) begin
        link.devAdOe <= mWr;
      end else if (tNxt == T_DATA && !tWr_r) begin
        link.devAd <= tMem[tIdx_r];
        link.devAdOe <= 1'b1;
      end
      link.devCtl[CTL_FRAME] <= mNxt != M_ADDR; // see [R3]
      link.devCtl[CTL_IRDY] <= mNxt != M_DATA; // see [R5]
      link.devCtl[CTL_TRDY] <= tNxt != T_DATA; // see [R6]
      link.devCtl[CTL_DEVSEL] <= !(tNxt inside {T_CLAIM, T_DATA, T_STOP});
      link.devCtl[CTL_STOP] <= tNxt != T_STOP; // see [R10] [R11]
      link.devCtlOe[CTL_FRAME] <= mNxt != M_IDLE;
      link.devCtlOe[CTL_IRDY] <= mNxt != M_IDLE;
      link.devCtlOe[CTL_TRDY] <= tNxt != T_IDLE; // see [R7]
      link.devCtlOe[CTL_DEVSEL] <= tNxt != T_IDLE;
      link.devCtlOe[CTL_STOP] <= tNxt != T_IDLE;
    end
  end

  // hold: bus passes on only once the processor acknowledges
  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      hold_r <= 1'b0;
      gnt_r <= 1'b0;
    end else begin
      hold_r <= link.peripheral_bus_request;
      gnt_r <= hold_r && ackS && (gnt_r || mState_r == M_IDLE); // see [R16]
    end
  end

  // a retried cycle while the other side waits for the bus could lock
  // both bridges; back the processor off until the hold is over
  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      cpu_backoff_n <= 1'b1;
    end else if (mEnd && term == TERM_RETRY && hold_r) begin
      cpu_backoff_n <= 1'b0; // see [R19]
    end else if (!hold_r) begin
      cpu_backoff_n <= 1'b1;
    end
  end

  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      cpu_address_float <= 1'b0;
      link.pci_atomic_flag_n <= 1'b1;
    end else begin
      cpu_address_float <= snoopReq || tState_r != T_IDLE; // see [R17]
      link.pci_atomic_flag_n <= lockNS; // see [R18]
    end
  end

  // strap is caught while reset is still held low
  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      testMode <= !link.peripheral_bus_request; // see [R14]
    end
  end

  always_ff @(posedge local_bus_clock) begin
    if (!rstn) begin
      isa_low_address <= 9'h000;
    end else if (link.isaMaster) begin
      isa_low_address <= link.ad[8:0]; // see [R13]
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pci_agent_end.sv ----
// peripheral-side agent: pci target and requesting master on the link
`timescale 1ns/1ps
`default_nettype none
module pci_agent_end
  import pci_bridge_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  pci_link_if.agt link,
  input wire logic reqValid,
  input wire logic [3:0] reqCmd,
  input wire logic [31:0] reqAddr,
  input wire logic [31:0] reqData,
  input wire logic [1:0] tgtMode,
  input wire logic isaActive,
  input wire logic [8:0] isaAddr,
  input wire logic strapTestN,
  output logic reqBusy,
  output logic reqDone,
  output logic [31:0] reqRdData,
  output logic [1:0] reqTerm
);
  logic clk;
  logic reqTog_r, doneTog_r, seen_r;
  logic [2:0] doneS_r;
  logic [31:0] uAddr_r, uData_r;
  logic [3:0] uCmd_r;
  logic [15:0] cfgA_r, cfgB_r;
  logic [1:0] rstS_r, togS_r;
  logic lrstn, isaS, frameN, irdyN, trdyN, devselN, stopN, aEnd;
  logic [1:0] modeS, gMode_r, gIdx_r;
  logic gWr_r, prevFrameN_r;
  logic [2:0] cnt_r;
  logic [31:0] rd_r;
  term_t term, term_r;
  agt_t aState_r, aNxt;
  tgt_t gState_r, gNxt;
  logic [31:0] gMem [4];

  assign clk = link.local_bus_clock;
  assign frameN = link.ctl[CTL_FRAME];
  assign irdyN = link.ctl[CTL_IRDY];
  assign trdyN = link.ctl[CTL_TRDY];
  assign devselN = link.ctl[CTL_DEVSEL];
  assign stopN = link.ctl[CTL_STOP];
  assign lrstn = rstS_r[1];
  assign {modeS, isaS} = cfgB_r[15:13];

  // user side on mclk; the request words stay still until done
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reqTog_r <= 1'b0;
      reqBusy <= 1'b0;
      reqDone <= 1'b0;
      doneS_r <= 3'h0;
      reqRdData <= ALL_ONES;
      reqTerm <= TERM_OK;
    end else begin
      doneS_r <= {doneS_r[1:0], doneTog_r};
      reqDone <= doneS_r[2] != doneS_r[1];
      if (doneS_r[2] != doneS_r[1]) begin
        reqBusy <= 1'b0;
        reqRdData <= rd_r;
        reqTerm <= term_r;
      end else if (reqValid && !reqBusy) begin
        reqBusy <= 1'b1;
        reqTog_r <= !reqTog_r;
        uAddr_r <= reqAddr;
        uData_r <= reqData;
        uCmd_r <= reqCmd;
      end
    end
  end

  // link side: reset, toggle and slow configuration levels cross over
  always_ff @(posedge clk) begin
    rstS_r <= {rstS_r[0], rstn};
    togS_r <= {togS_r[0], reqTog_r};
    cfgA_r <= {tgtMode, isaActive, isaAddr, strapTestN, 3'h0};
    cfgB_r <= cfgA_r;
  end

  assign aEnd = aState_r == A_DATA && ((!trdyN && !devselN) || !stopN
    || (devselN && cnt_r >= MABORT_CLKS));

  always_comb begin
    if (!trdyN && !devselN) begin
      term = TERM_OK;
    end else if (!stopN && !devselN) begin
      term = TERM_RETRY;
    end else if (!stopN) begin
      term = TERM_TABORT;
    end else begin
      term = TERM_MABORT;
    end
  end

  always_comb begin
    aNxt = aState_r;
    unique case (aState_r)
      A_IDLE: if (togS_r[1] != seen_r) aNxt = A_REQ;
      A_REQ: if (link.gnt && frameN && irdyN) aNxt = A_ADDR;
      A_ADDR: aNxt = A_DATA;
      A_DATA: if (aEnd) aNxt = A_TURN;
      A_TURN: aNxt = A_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!lrstn) begin
      aState_r <= A_IDLE;
      seen_r <= togS_r[1];
      doneTog_r <= 1'b0;
      cnt_r <= 3'h0;
      term_r <= TERM_OK;
      rd_r <= ALL_ONES;
    end else begin
      aState_r <= aNxt;
      cnt_r <= (aState_r == A_DATA) ? cnt_r + 3'h1 : 3'h1;
      if (aState_r == A_IDLE) seen_r <= togS_r[1];
      if (aEnd) begin
        term_r <= term;
        rd_r <= (term == TERM_OK) ? link.ad : ALL_ONES;
        doneTog_r <= !doneTog_r;
      end
    end
  end

  always_comb begin
    gNxt = gState_r;
    unique case (gState_r)
      T_IDLE: begin
        if (!frameN && prevFrameN_r
            && (aState_r == A_REQ || aState_r == A_IDLE)
            && link.ad[31:28] == AGT_WIN && modeS != TERM_MABORT) begin
          gNxt = T_CLAIM;
        end
      end
      T_CLAIM: gNxt = (gMode_r == TERM_OK) ? T_DATA : T_STOP;
      T_DATA: if (!irdyN) gNxt = frameN ? T_TURN : T_STOP;
      T_STOP: if (frameN) gNxt = T_TURN;
      T_TURN: gNxt = T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!lrstn) begin
      gState_r <= T_IDLE;
      prevFrameN_r <= 1'b1;
    end else begin
      gState_r <= gNxt;
      prevFrameN_r <= frameN;
    end
    if (gState_r == T_IDLE) begin
      gIdx_r <= link.ad[3:2];
      gWr_r <= link.cbe[0];
      gMode_r <= modeS;
    end
    if (gState_r == T_DATA && !irdyN && gWr_r) gMem[gIdx_r] <= link.ad;
  end

  // during reset the request pin carries the strap level
  always_ff @(posedge clk) begin
    if (!lrstn) begin
      link.peripheral_bus_request <= cfgB_r[3];
      link.isaMaster <= 1'b0;
      link.agtAdOe <= 1'b0;
      link.agtCbeOe <= 1'b0;
      link.agtCtlOe <= 5'h00;
      link.agtCtl <= CTL_IDLE;
    end else begin
      link.peripheral_bus_request <= isaS || aNxt != A_IDLE;
      link.isaMaster <= isaS && link.gnt && aNxt == A_IDLE;
      link.agtAd <= (aNxt == A_ADDR) ? uAddr_r : uData_r;
      link.agtAdOe <= aNxt == A_ADDR || (aNxt == A_DATA && uCmd_r[0]);
      link.agtCbe <= (aNxt == A_ADDR) ? uCmd_r : 4'h0;
      link.agtCbeOe <= aNxt inside {A_ADDR, A_DATA};
      if (isaS && link.gnt && aNxt == A_IDLE) begin
        link.agtAd <= {23'h000000, cfgB_r[12:4]};
        link.agtAdOe <= 1'b1;
      end else if (gNxt == T_DATA && !gWr_r) begin
        link.agtAd <= gMem[gIdx_r];
        link.agtAdOe <= 1'b1;
      end
      link.agtCtl[CTL_FRAME] <= aNxt != A_ADDR;
      link.agtCtl[CTL_IRDY] <= aNxt != A_DATA;
      link.agtCtl[CTL_TRDY] <= gNxt != T_DATA;
      link.agtCtl[CTL_DEVSEL] <= !(gNxt inside {T_CLAIM, T_DATA}
        || (gNxt == T_STOP && gMode_r != TERM_TABORT));
      link.agtCtl[CTL_STOP] <= gNxt != T_STOP;
      link.agtCtlOe[CTL_FRAME] <= aNxt inside {A_ADDR, A_DATA, A_TURN};
      link.agtCtlOe[CTL_IRDY] <= aNxt inside {A_ADDR, A_DATA, A_TURN};
      link.agtCtlOe[CTL_TRDY] <= gNxt != T_IDLE;
      link.agtCtlOe[CTL_DEVSEL] <= gNxt != T_IDLE;
      link.agtCtlOe[CTL_STOP] <= gNxt != T_IDLE;
    end
  end
endmodule
`default_nettype wire

// ---- verification/pci_link_checker.sv ----
// concurrent checks on the bridge-to-agent link
`timescale 1ns/1ps
`default_nettype none
module pci_link_checker
  import pci_bridge_pkg::*;
(
  input wire logic local_bus_clock,
  input wire logic rstn,
  input wire logic [31:0] ad,
  input wire logic [4:0] ctl,
  input wire logic [4:0] devCtl,
  input wire logic [4:0] devCtlOe,
  input wire logic [4:0] agtCtlOe,
  input wire logic devAdOe,
  input wire logic gnt,
  input wire logic peripheral_bus_request
);
  default clocking cb @(posedge local_bus_clock); endclocking
  default disable iff (!rstn);
  sequence devFrame;
    devCtlOe[CTL_FRAME] && $fell(ctl[CTL_FRAME]);
  endsequence
  sequence noClaim3;
    ctl[CTL_DEVSEL] [*3];
  endsequence
  sequence noClaim6;
    ctl[CTL_DEVSEL] [*6];
  endsequence
  reset_ad_drive_a: assert property (disable iff (1'b0)
    (!rstn && $past(!rstn)) |-> (devAdOe && ad == AD_RESET))
    else $error("address/data left floating in reset");
  trdy_owner_a: assert property (
    (devCtlOe[CTL_TRDY] && !devCtl[CTL_TRDY])
    |-> (devCtlOe[CTL_DEVSEL] && !devCtl[CTL_DEVSEL]))
    else $error("target ready driven without a claim");
  owner_frame_a: assert property (
    (devCtlOe[CTL_FRAME] && !devCtl[CTL_FRAME]) |-> !gnt)
    else $error("bridge framed while bus granted away");
  irdy_owner_a: assert property (
    agtCtlOe[CTL_FRAME] |-> !(devCtlOe[CTL_IRDY] && !devCtl[CTL_IRDY]))
    else $error("bridge drove initiator ready as target");
  wait_state_a: assert property (
    (devCtlOe[CTL_IRDY] && !ctl[CTL_IRDY] && !ctl[CTL_DEVSEL]
     && ctl[CTL_TRDY] && ctl[CTL_STOP]) |=> !ctl[CTL_IRDY])
    else $error("data phase left before target ready");
  stop_release_a: assert property (
    (devCtlOe[CTL_IRDY] && !ctl[CTL_STOP]) |-> ##[0:3] ctl[CTL_FRAME])
    else $error("frame held past three clocks after stop");
  stop_held_a: assert property (
    (devCtlOe[CTL_STOP] && !devCtl[CTL_STOP] && !ctl[CTL_FRAME])
    |=> (devCtlOe[CTL_STOP] && !devCtl[CTL_STOP]))
    else $error("stop dropped while frame still low");
  early_abort_a: assert property (
    devFrame ##1 noClaim3 |-> !ctl[CTL_IRDY])
    else $error("master abort taken too early");
  master_abort_a: assert property (
    devFrame ##0 noClaim6 |-> ##[0:3] (ctl[CTL_IRDY] && ctl[CTL_FRAME]))
    else $error("unclaimed cycle not ended");
  claim_time_a: assert property (
    (agtCtlOe[CTL_FRAME] && $fell(ctl[CTL_FRAME]) && ad[31:28] == DEV_WIN)
    |=> !ctl[CTL_DEVSEL])
    else $error("bridge window access not claimed");
  grant_after_a: assert property (
    $rose(gnt) |-> $past(peripheral_bus_request, 2))
    else $error("grant without prior hold request");
endmodule
`default_nettype wire

// ---- verification/cpu_to_pci_bridge_arbitration_bench.sv ----
// self-checking bench joining the bridge and the agent on one link
`timescale 1ns/1ps
`default_nettype none
module cpu_to_pci_bridge_arbitration_bench;
  import pci_bridge_pkg::*;
  logic mclk = 1'b0;
  logic lbc = 1'b0;
  logic rstn = 1'b0;
  logic cpuReq = 1'b0, cpuLocal = 1'b0, cpuLockN = 1'b1, snoopReq = 1'b0;
  logic tgtRetry = 1'b0, grantAck = 1'b0, blockAck = 1'b0;
  logic [3:0] cpuCmd = 4'h0, reqCmd = 4'h0;
  logic [31:0] cpuAddr = 32'h0, cpuWrData = 32'h0;
  logic [31:0] reqAddr = 32'h0, reqData = 32'h0;
  logic reqValid = 1'b0, isaActive = 1'b0, strapTestN = 1'b1;
  logic [1:0] tgtMode = 2'h0;
  logic [8:0] isaAddr = 9'h0;
  logic cpuDone, cpuHold, addrFloat, backoffN, testMode, reqBusy, reqDone;
  logic [31:0] cpuRdData, reqRdData, wd [4];
  logic [1:0] cpuTerm, reqTerm;
  logic [8:0] isaLow;
  logic [67:0] bq [$], aq [$];
  logic boPend = 1'b0, frPrev = 1'b1;
  int errTotal = 0, nChecks = 0, cyc = 0, seed = 60253;
  always #12.5 mclk = ~mclk;
  // odd offset keeps the two clocks' edges apart
  always begin
    if ($time == 0) #7;
    #62.5 lbc = ~lbc;
  end
  pci_link_if link (.local_bus_clock(lbc));
  pci_bridge_device i_pci_bridge_device (.local_bus_clock(lbc),
    .rstn(rstn), .link(link), .cpuReq(cpuReq), .cpuLocal(cpuLocal),
    .cpuCmd(cpuCmd), .cpuAddr(cpuAddr), .cpuByteEn(4'h0),
    .cpuWrData(cpuWrData), .cpuLockN(cpuLockN), .snoopReq(snoopReq),
    .tgtRetry(tgtRetry), .cpu_grant_ack(grantAck), .cpuDone(cpuDone),
    .cpuRdData(cpuRdData), .cpuTerm(cpuTerm), .cpuHold(cpuHold),
    .cpu_address_float(addrFloat), .cpu_backoff_n(backoffN),
    .testMode(testMode), .isa_low_address(isaLow));
  pci_agent_end i_pci_agent_end (.mclk(mclk), .rstn(rstn), .link(link),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr),
    .reqData(reqData), .tgtMode(tgtMode), .isaActive(isaActive),
    .isaAddr(isaAddr), .strapTestN(strapTestN), .reqBusy(reqBusy),
    .reqDone(reqDone), .reqRdData(reqRdData), .reqTerm(reqTerm));
  pci_link_checker i_pci_link_checker (.local_bus_clock(lbc),
    .rstn(rstn), .ad(link.ad), .ctl(link.ctl), .devCtl(link.devCtl),
    .devCtlOe(link.devCtlOe), .agtCtlOe(link.agtCtlOe),
    .devAdOe(link.devAdOe), .gnt(link.gnt),
    .peripheral_bus_request(link.peripheral_bus_request));
  task automatic finishTest();
    // a cycle that never finished leaves its note behind
    chk(34'(bq.size() + aq.size()), 34'h0);
    if (errTotal == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // note layout: mask above, masked expectation below
  function automatic logic [67:0] ex(logic [1:0] t, logic [31:0] d,
    logic dm);
    ex = {2'h3, {32{dm}}, t, d & {32{dm}}};
  endfunction
  task automatic lw(input int n);
    repeat (n) @(negedge lbc);
  endtask
  task automatic cpu(input logic loc, input logic [3:0] cmd,
    input logic [31:0] a, input logic [31:0] d, input logic [67:0] e);
    int n;
    n = 0;
    @(negedge lbc);
    cpuLocal = loc;
    cpuCmd = cmd;
    cpuAddr = a;
    cpuWrData = d;
    cpuReq = 1'b1;
    if (!loc) bq.push_back(e);
    @(negedge lbc);
    cpuReq = 1'b0;
    while (!loc && cpuDone !== 1'b1 && n < 60) begin
      @(negedge lbc);
      n++;
    end
    cpuLocal = 1'b0;
  endtask
  task automatic agt(input logic [3:0] cmd, input logic [31:0] a,
    input logic [31:0] d, input logic [67:0] e);
    int n;
    n = 0;
    @(negedge mclk);
    reqCmd = cmd;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    aq.push_back(e);
    @(negedge mclk);
    reqValid = 1'b0;
    while (reqDone !== 1'b1 && n < 900) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic doReset(input logic s);
    @(negedge lbc);
    rstn = 1'b0;
    strapTestN = s;
    lw(6);
    rstn = 1'b1;
    lw(6);
    chk({33'h0, testMode}, {33'h0, ~s});
  endtask
  // the processor side acknowledges any hold on the next falling edge unless blockAck is set
  always @(negedge lbc) grantAck <= cpuHold === 1'b1 && !blockAck;
  always @(negedge lbc) begin
    logic [67:0] e;
    if (boPend) chk({33'h0, backoffN}, 34'h0);
    boPend = cpuDone === 1'b1 && cpuTerm === TERM_RETRY && cpuHold === 1'b1;
    if (cpuDone === 1'b1 && bq.size() == 0) chk(34'h1, 34'h0);
    if (cpuDone === 1'b1 && bq.size() != 0) begin
      e = bq.pop_front();
      chk({cpuTerm, cpuRdData} & e[67:34], e[33:0]);
    end
    if (link.ctl[4] === 1'b0 && frPrev === 1'b1 && link.devCtlOe[4]) begin
      chk({2'h0, link.ad}, {2'h0, cpuAddr});
      chk({30'h0, link.cbe}, {30'h0, cpuCmd});
    end
    frPrev = link.ctl[4];
  end
  always @(negedge mclk) begin
    logic [67:0] e;
    if (reqDone === 1'b1 && aq.size() == 0) chk(34'h1, 34'h0);
    if (reqDone === 1'b1 && aq.size() != 0) begin
      e = aq.pop_front();
      chk({reqTerm, reqRdData} & e[67:34], e[33:0]);
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errTotal++;
      finishTest();
    end
  end
  initial begin
    doReset(1'b1);
    for (int m = 0; m < 4; m++) begin
      tgtMode = m[1:0];
      wd[0] = $random(seed);
      cpu(0, 4'h7, 32'h80000000 | (m << 2), wd[0], ex(m[1:0], 0, 0));
      cpu(0, 4'h6, 32'h80000000 | (m << 2), 0,
        ex(m[1:0], (m == 3) ? ALL_ONES : wd[0], m == 0 || m == 3));
    end
    tgtMode = 2'h0;
    for (int k = 0; k < 4; k++) begin
      wd[k] = $random(seed);
      agt(4'h7, k << 2, wd[k], ex(TERM_OK, 0, 0));
    end
    for (int k = 0; k < 4; k++) agt(4'h6, k << 2, 0, ex(TERM_OK, wd[k], 1));
    tgtRetry = 1'b1;
    agt(4'h7, 32'h4, ~wd[1], ex(TERM_RETRY, 0, 0));
    tgtRetry = 1'b0;
    agt(4'h6, 32'h4, 0, ex(TERM_OK, wd[1], 1));
    agt(4'h6, 32'h40000000, 0, ex(TERM_MABORT, ALL_ONES, 1));
    // retried processor cycle racing a bus request
    blockAck = 1'b1;
    tgtMode = 2'h1;
    fork
      cpu(0, 4'h7, 32'h80000000, 0, ex(TERM_RETRY, 0, 0));
      agt(4'h7, 32'h8, 32'h5A5AA5A5, ex(TERM_OK, 0, 0));
      begin
        lw(14);
        chk({33'h0, link.gnt}, 34'h0);
        blockAck = 1'b0;
      end
    join
    tgtMode = 2'h0;
    lw(8);
    chk({33'h0, backoffN}, 34'h1);
    cpuLockN = 1'b0;
    lw(6);
    chk({33'h0, link.pci_atomic_flag_n}, 34'h0);
    cpu(0, 4'h7, 32'h80000004, 0, ex(TERM_OK, 0, 0));
    cpuLockN = 1'b1;
    lw(6);
    chk({33'h0, link.pci_atomic_flag_n}, 34'h1);
    snoopReq = 1'b1;
    lw(4);
    chk({33'h0, addrFloat}, 34'h1);
    snoopReq = 1'b0;
    lw(4);
    chk({33'h0, addrFloat}, 34'h0);
    isaAddr = $random(seed);
    isaActive = 1'b1;
    lw(12);
    chk({25'h0, isaLow}, {25'h0, isaAddr});
    isaActive = 1'b0;
    cpu(1, 4'h6, 32'h00100000, 0, 0);
    lw(10);
    doReset(1'b0);
    finishTest();
  end
endmodule
`default_nettype wire
